// *** logic/bhd_defs.svh ***
// Constants for the hall commutation decoder.
// Assumes inclusion by bare name from design files.
`ifndef BHD_DEFS_SVH
`define BHD_DEFS_SVH
`define BHD_PWM_FREQ_HZ 18000
`define BHD_CLK_FREQ_HZ 250000000
`define BHD_PWM_PERIOD_CYC (`BHD_CLK_FREQ_HZ / `BHD_PWM_FREQ_HZ)
`define BHD_PHASE_NONE 3'h0
`define BHD_PHASE_1 3'h1
`define BHD_PHASE_2 3'h2
`define BHD_PHASE_3 3'h4
`endif

// *** logic/bhd_pkg.sv ***
// Types for the hall commutation decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package bhd_pkg;
    typedef logic [2:0] bhd_phase_type;
    typedef enum logic [1:0]
    {
        BHD_PWM_ON = 2'h1,
        BHD_PWM_OFF = 2'h2
    } bhd_pwm_state_type;
endpackage

// *** logic/bhd_chop_if.sv ***
// Chopper link between the decoder top and its PWM generator.
// Assumes a single clock domain.
interface bhd_chop_if;
    logic [15:0] duty;
    logic chop_on;
    modport gen (input duty, output chop_on);
    modport user (output duty, input chop_on);
endinterface

// *** logic/bhd_pwm.sv ***
// PWM chopper running at a fixed carrier rate.
// Assumes clk at the rate given in the defs header.
`include "bhd_defs.svh"
module bhd_pwm #(
    parameter int PERIOD_CYC = `BHD_PWM_PERIOD_CYC
)(
    input wire logic clk,
    input wire logic sys_rst,
    bhd_chop_if.gen chop
);
    logic [15:0] count;
    bhd_pkg::bhd_pwm_state_type state;

    // Free-running carrier counter
    always_ff @(posedge clk)
    begin
        if (sys_rst || count == 16'(PERIOD_CYC - 1))
            count <= 16'h0;
        else
            count <= count + 16'h1;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            state <= bhd_pkg::BHD_PWM_OFF;
        else if (count < chop.duty)
            state <= bhd_pkg::BHD_PWM_ON;
        else
            state <= bhd_pkg::BHD_PWM_OFF;
    end

    assign chop.chop_on = (state == bhd_pkg::BHD_PWM_ON);
endmodule

// *** logic/bhd_decoder.sv ***
// Commutation decoder for a three-phase brushless motor drive.
// Assumes hall inputs and controls synchronous to clk.
`include "bhd_defs.svh"
module bhd_decoder #(
    parameter int PERIOD_CYC = `BHD_PWM_PERIOD_CYC
)(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic rotor_sensor_a,
    input wire logic rotor_sensor_b,
    input wire logic rotor_sensor_c,
    input wire logic spacing_120,
    input wire logic reverse,
    input wire logic brake,
    input wire logic [15:0] duty,
    output logic [2:0] source_en,
    output logic [2:0] sink_en
);
    bhd_chop_if chop();
    logic [2:0] hall;
    bhd_pkg::bhd_phase_type fwd_src;
    bhd_pkg::bhd_phase_type fwd_snk;
    bhd_pkg::bhd_phase_type dir_src;
    bhd_pkg::bhd_phase_type dir_snk;
    logic [5:0] pair;
    logic [2:0] next_source;
    logic [2:0] next_sink;

    // Returns {source, sink} one-hot phases for a 60-degree hall code
    function automatic logic [5:0] decode_60(input logic [2:0] code);
        logic [2:0] src;
        logic [2:0] snk;
        src = `BHD_PHASE_NONE;
        snk = `BHD_PHASE_NONE;
        unique case (code)
            3'h0:
            begin
                src = `BHD_PHASE_2;
                snk = `BHD_PHASE_1;
            end
            3'h4:
            begin
                src = `BHD_PHASE_2;
                snk = `BHD_PHASE_3;
            end
            3'h6:
            begin
                src = `BHD_PHASE_1;
                snk = `BHD_PHASE_3;
            end
            3'h7:
            begin
                src = `BHD_PHASE_1;
                snk = `BHD_PHASE_2;
            end
            3'h3:
            begin
                src = `BHD_PHASE_3;
                snk = `BHD_PHASE_2;
            end
            3'h1:
            begin
                src = `BHD_PHASE_3;
                snk = `BHD_PHASE_1;
            end
            // Codes 010 and 101 cannot occur with 60-degree spacing
            default:
            begin
                src = `BHD_PHASE_NONE;
                snk = `BHD_PHASE_NONE;
            end
        endcase
        return {src, snk};
    endfunction

    // Returns {source, sink} one-hot phases for a 120-degree hall code
    function automatic logic [5:0] decode_120(input logic [2:0] code);
        logic [2:0] src;
        logic [2:0] snk;
        src = `BHD_PHASE_NONE;
        snk = `BHD_PHASE_NONE;
        unique case (code)
            3'h1:
            begin
                src = `BHD_PHASE_2;
                snk = `BHD_PHASE_1;
            end
            3'h5:
            begin
                src = `BHD_PHASE_2;
                snk = `BHD_PHASE_3;
            end
            3'h4:
            begin
                src = `BHD_PHASE_1;
                snk = `BHD_PHASE_3;
            end
            3'h6:
            begin
                src = `BHD_PHASE_1;
                snk = `BHD_PHASE_2;
            end
            3'h2:
            begin
                src = `BHD_PHASE_3;
                snk = `BHD_PHASE_2;
            end
            3'h3:
            begin
                src = `BHD_PHASE_3;
                snk = `BHD_PHASE_1;
            end
            // All sensors equal means a broken sensor or cable
            default:
            begin
                src = `BHD_PHASE_NONE;
                snk = `BHD_PHASE_NONE;
            end
        endcase
        return {src, snk};
    endfunction

    // Picks the table that matches the sensor spacing
    function automatic logic [5:0] decode(input logic mode120, input logic [2:0] code);
        logic [5:0] r;
        r = {`BHD_PHASE_NONE, `BHD_PHASE_NONE};
        if (mode120)
        begin
            r = decode_120(code);
        end
        else
        begin
            r = decode_60(code);
        end
        return r;
    endfunction

    // Sensor a is the most significant bit of the code
    assign hall = {rotor_sensor_a, rotor_sensor_b, rotor_sensor_c};
    assign pair = decode(spacing_120, hall);
    assign fwd_src = pair[5:3];
    assign fwd_snk = pair[2:0];
    assign chop.duty = duty;

    // Reverse runs the same table with the two roles exchanged
    always_comb
    begin
        dir_src = fwd_src;
        dir_snk = fwd_snk;
        if (reverse)
        begin
            dir_src = fwd_snk;
            dir_snk = fwd_src;
        end
    end

    bhd_pwm #(
        .PERIOD_CYC(PERIOD_CYC)
    ) u_pwm (
        .clk(clk),
        .sys_rst(sys_rst),
        .chop(chop)
    );

    // One output stage per phase
    for (genvar i = 0; i < 3; i++)
    begin : g_phase
        // Chopping only the source keeps the sink as the return path
        always_comb
        begin
            next_source[i] = dir_src[i];
            if (brake)
            begin
                next_source[i] = 1'b0;
            end
            else if (!chop.chop_on)
            begin
                next_source[i] = 1'b0;
            end
        end

        always_comb
        begin
            next_sink[i] = dir_snk[i];
            if (brake)
            begin
                next_sink[i] = 1'b1;
            end
        end

        always_ff @(posedge clk)
        begin
            if (sys_rst)
                source_en[i] <= 1'b0;
            else
                source_en[i] <= next_source[i];
        end

        always_ff @(posedge clk)
        begin
            if (sys_rst)
                sink_en[i] <= 1'b0;
            else
                sink_en[i] <= next_sink[i];
        end
    end
endmodule

// *** testbench/bhd_tb_pkg.sv ***
// Expected phase table, index {spacing_120, a, b, c}, entry {source, sink}.
package bhd_tb_pkg;
    localparam logic [5:0] TBL [16] = '{6'h11, 6'h21, 6'h00, 6'h22, 6'h14, 6'h00, 6'h0c,
        6'h0a, 6'h00, 6'h11, 6'h22, 6'h21, 6'h0c, 6'h14, 6'h0a, 6'h00};
endpackage

// *** testbench/bhd_hall_model.sv ***
// Hall sensor model: three sensor levels from a rotor code, high means one.
module bhd_hall_model (
    input wire logic [2:0] code,
    output logic rotor_sensor_a,
    output logic rotor_sensor_b,
    output logic rotor_sensor_c
);
    timeunit 1ns;
    timeprecision 1ps;
    assign {rotor_sensor_a, rotor_sensor_b, rotor_sensor_c} = code;
endmodule

// *** testbench/bhd_checker.sv ***
// Port checker for the decoder; bound to every decoder instance.
module bhd_checker #(parameter int PERIOD_CYC = 16) (
    input wire logic clk, sys_rst, rotor_sensor_a, rotor_sensor_b, rotor_sensor_c,
    input wire logic spacing_120, reverse, brake,
    input wire logic [15:0] duty,
    input wire logic [2:0] source_en, sink_en
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic [5:0] e = bhd_tb_pkg::TBL[{spacing_120, rotor_sensor_a, rotor_sensor_b,
        rotor_sensor_c}];
    wire logic [2:0] xs = reverse ? e[2:0] : e[5:3];
    wire logic [2:0] xk = reverse ? e[5:3] : e[2:0];
    wire logic full = duty >= PERIOD_CYC;
    chk_brake_override: assert property (brake |=> source_en == 3'h0 && sink_en == 3'h7)
        else $error("brake outputs wrong");
    chk_invalid_idle: assert property (spacing_120 && !brake && e == 6'h0 |=> {source_en, sink_en} == 6'h0)
        else $error("invalid code drives a phase");
    chk_sink_table: assert property (!brake && e != 6'h0 |=> sink_en == $past(xk))
        else $error("sink phase wrong");
    chk_source_full: assert property (!brake && e != 6'h0 && full && $past(full) && !$past(sys_rst) |=> source_en == $past(xs))
        else $error("source phase wrong at full duty");
    chk_chop_off: assert property (duty == 16'h0 && $past(duty) == 16'h0 |=> source_en == 3'h0)
        else $error("source on at zero duty");
    chk_no_overlap: assert property ((source_en & sink_en) == 3'h0)
        else $error("phase both sourced and sunk");
    chk_source_onehot: assert property ($onehot0(source_en))
        else $error("several sources on");
endmodule
bind bhd_decoder bhd_checker #(.PERIOD_CYC(PERIOD_CYC)) i_chk (.clk(clk), .sys_rst(sys_rst),
    .rotor_sensor_a(rotor_sensor_a), .rotor_sensor_b(rotor_sensor_b),
    .rotor_sensor_c(rotor_sensor_c), .spacing_120(spacing_120), .reverse(reverse),
    .brake(brake), .duty(duty), .source_en(source_en), .sink_en(sink_en));

// *** testbench/bldc_hall_commutation_decoder_tb_top.sv ***
// Bench for the decoder: full table sweep with brake, then random runs at full or zero duty.
module bldc_hall_commutation_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, sys_rst = 1, spacing_120 = 0, reverse = 0, brake = 0;
    logic [2:0] code = 3'h0;
    logic [15:0] duty = 16'h0;
    wire logic rotor_sensor_a, rotor_sensor_b, rotor_sensor_c;
    wire logic [2:0] source_en, sink_en;
    logic [5:0] q[$];
    int n_errors = 0, n_compared = 0, cyc = 0;
    bhd_hall_model i_hall (.*);
    bhd_decoder #(.PERIOD_CYC(16)) i_dut (.clk(clk), .sys_rst(sys_rst),
        .rotor_sensor_a(rotor_sensor_a), .rotor_sensor_b(rotor_sensor_b),
        .rotor_sensor_c(rotor_sensor_c), .spacing_120(spacing_120), .reverse(reverse),
        .brake(brake), .duty(duty), .source_en(source_en), .sink_en(sink_en));
    initial forever #2 clk = ~clk;
    task automatic end_of_test();
        if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk)
        if (++cyc == 2000)
        begin
            n_errors++;
            end_of_test();
        end
    always @(negedge clk)
        if (q.size() > 0)
        begin
            logic [5:0] e;
            e = q.pop_front();
            n_compared++;
            if ({source_en, sink_en} !== e)
            begin
                $display("CHECK FAILED outputs exp %h got %h", e, {source_en, sink_en});
                n_errors++;
            end
        end
    // Vector is {brake, spacing_120, reverse, code}; note taken once outputs settle
    task automatic apply(input logic [5:0] v, input logic [15:0] d);
        logic [5:0] t;
        {brake, spacing_120, reverse, code} = v;
        duty = d;
        t = bhd_tb_pkg::TBL[{v[4], v[2:0]}];
        if (reverse) t = {t[2:0], t[5:3]};
        if (d == 16'h0) t[5:3] = 3'h0;
        if (brake) t = 6'h07;
        repeat (3) @(posedge clk);
        #1;
        q.push_back(t);
    endtask
    initial
    begin
        void'($urandom(32'h8db6aa77));
        repeat (6) @(posedge clk);
        #1;
        sys_rst = 0;
        for (int i = 0; i < 64; i++) apply(6'(i), 16'hffff);
        for (int i = 0; i < 60; i++) apply(6'($urandom), $urandom % 2 ? 16'hffff : 16'h0);
        end_of_test();
    end
endmodule
